// >>> core/lookup_table_access.sv
`timescale 1ns/1ps
`include "lookup_table_access_consts.svh"

// Summary of operation
// R1: Search end shows 14-bit valid entry count
// R2: Launch flag set by software, cleared when done
// R3: Ready flag set when next entry loaded
// R4: Reading entry word four clears ready flag
// R5: Combined bit: entry ready or search ended
// R6: Direct bit set selects direct table indexing
// R7: Direct bit clear (reset) selects hashed lookup
// R8: Operation codes: none, write, read, search
// R9: Index registers address; entry registers carry data
// R10: Hashed key is group id plus address
// R11: Direct mode uses low 12 index bits
// R12: Operation and direct bits frozen while busy
module lookup_table_access
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Register access port
  input  wire logic [15:0]  reg_addr_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  input  wire logic [31:0]  reg_wdata_i,
  output logic [31:0]       reg_rdata_o,
  output logic              reg_rvalid_o,
  // Lookup engine request
  output logic              tbl_req_o,
  output logic [1:0]        tbl_op_o,
  output logic              tbl_direct_o,
  output logic [6:0]        tbl_hash_fid_o,
  output logic [47:0]       tbl_hash_mac_o,
  output logic [11:0]       tbl_direct_addr_o,
  output logic [127:0]      tbl_wdata_o,
  // Lookup engine answer
  input  wire logic         tbl_done_i,
  input  wire logic         tbl_entry_valid_i,
  input  wire logic [127:0] tbl_rdata_i,
  input  wire logic [13:0]  tbl_count_i,
  output logic              tbl_entry_ack_o
);

  // Address decode shared by write and read paths
  function automatic logic word_hit(input logic [15:0] a, input logic [15:0] off);
    word_hit = (a[15:2] == off[15:2]);
  endfunction : word_hit

  // Entry word decode: 0x420..0x42f
  function automatic logic entry_hit(input logic [15:0] a);
    entry_hit = (a[15:4] == 12'(`LTA_ENTRY1_OFF >> 4));
  endfunction : entry_hit

  lookup_table_access_pkg::state_t state_r, state_nxt;  // Controller state
  lookup_table_access_pkg::op_t    op_r, op_nxt;        // Selected operation
  logic        direct_r, direct_nxt;   // Direct addressing
  logic [1:0]  spare_r, spare_nxt;     // Reserved read/write bits 4:3
  logic        launch_r, launch_nxt;   // Launch/done flag
  logic        ready_r, ready_nxt;     // Next entry ready
  logic        end_r, end_nxt;         // Search ended
  logic [13:0] count_r, count_nxt;     // Valid entry count
  logic [31:0] idx0_r, idx0_nxt;       // Index register 0
  logic [31:0] idx1_r, idx1_nxt;       // Index register 1
  logic [31:0] rdata_r, rdata_nxt;     // Control-side read data
  logic        rsel_r, rsel_nxt;       // Read came from entry bank
  logic        rvalid_r;               // Read data valid

  logic        start_go;               // Accepted launch
  logic        accept;                 // Search entry taken
  logic        xfer_done;              // Read/write finished
  logic        srch_done;              // Search finished
  logic        entry4_rd;              // Read of entry word 4
  logic [31:0] ctrl_word;              // Control register image

  entry_bank_if eb ();

  entry_bank u_bank
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .eb        (eb.bank)
  );

  // Control register image
  always_comb
  begin
    ctrl_word                                        = 32'h0;
    ctrl_word[`LTA_CTRL_CNT_MSB:`LTA_CTRL_CNT_LSB]  = count_r;       // R1
    ctrl_word[`LTA_CTRL_LAUNCH]                      = launch_r;
    ctrl_word[`LTA_CTRL_READY]                       = ready_r;
    ctrl_word[`LTA_CTRL_EITHER]                      = ready_r | end_r; // R5
    ctrl_word[4:3]                                   = spare_r;
    ctrl_word[`LTA_CTRL_DIRECT]                      = direct_r;
    ctrl_word[1:0]                                   = op_r;
  end

  // Event terms
  assign start_go  = reg_wr_i && word_hit(reg_addr_i, `LTA_CTRL_OFF)
                     && state_r == lookup_table_access_pkg::ST_IDLE
                     && reg_wdata_i[`LTA_CTRL_LAUNCH]
                     && reg_wdata_i[1:0] != lookup_table_access_pkg::OP_NOP;
  assign xfer_done = state_r == lookup_table_access_pkg::ST_XFER && tbl_done_i;
  assign srch_done = state_r == lookup_table_access_pkg::ST_SEARCH && tbl_done_i;
  assign accept    = state_r == lookup_table_access_pkg::ST_SEARCH
                     && tbl_entry_valid_i && !ready_r;
  assign entry4_rd = reg_rd_i && word_hit(reg_addr_i, `LTA_ENTRY4_LAST);

  // Controller next state
  always_comb
  begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    direct_nxt = direct_r;
    spare_nxt  = spare_r;
    launch_nxt = launch_r;
    end_nxt    = end_r;
    count_nxt  = count_r;
    idx0_nxt   = idx0_r;
    idx1_nxt   = idx1_r;
    // Software writes
    if (reg_wr_i && word_hit(reg_addr_i, `LTA_IDX0_OFF))
      idx0_nxt = reg_wdata_i & `LTA_IDX0_MASK;                      // R9
    if (reg_wr_i && word_hit(reg_addr_i, `LTA_IDX1_OFF))
      idx1_nxt = reg_wdata_i;                                       // R9
    if (reg_wr_i && word_hit(reg_addr_i, `LTA_CTRL_OFF))
    begin
      spare_nxt = reg_wdata_i[4:3];
      // Mode bits frozen while an operation runs
      if (state_r == lookup_table_access_pkg::ST_IDLE)
      begin
        op_nxt     = lookup_table_access_pkg::op_t'(reg_wdata_i[1:0]); // R12
        direct_nxt = reg_wdata_i[`LTA_CTRL_DIRECT];                    // R12
      end
    end
    // Launch decode
    if (start_go)
    begin
      launch_nxt = 1'b1;                                            // R2
      end_nxt    = 1'b0;
      if (reg_wdata_i[1:0] == lookup_table_access_pkg::OP_SEARCH)
        state_nxt = lookup_table_access_pkg::ST_SEARCH;             // R8
      else
        state_nxt = lookup_table_access_pkg::ST_XFER;               // R8
    end
    // Completion
    case (state_r)
      lookup_table_access_pkg::ST_IDLE:
        ;
      lookup_table_access_pkg::ST_XFER:
        if (tbl_done_i)
        begin
          launch_nxt = 1'b0;                                        // R2
          state_nxt  = lookup_table_access_pkg::ST_IDLE;
        end
      lookup_table_access_pkg::ST_SEARCH:
        if (tbl_done_i)
        begin
          launch_nxt = 1'b0;                                        // R2
          end_nxt    = 1'b1;
          count_nxt  = tbl_count_i;                                 // R1
          state_nxt  = lookup_table_access_pkg::ST_IDLE;
        end
      default:
        state_nxt = lookup_table_access_pkg::ST_IDLE;
    endcase
  end

  // Ready flag: set wins over the read-side clear
  always_comb
  begin
    ready_nxt = accept | (ready_r & ~entry4_rd);                    // R3 R4
  end

  // Read path next values
  always_comb
  begin
    rdata_nxt = rdata_r;
    rsel_nxt  = rsel_r;
    if (reg_rd_i)
    begin
      rsel_nxt = entry_hit(reg_addr_i);
      if (word_hit(reg_addr_i, `LTA_CTRL_OFF))
        rdata_nxt = ctrl_word;
      else if (word_hit(reg_addr_i, `LTA_IDX0_OFF))
        rdata_nxt = idx0_r;
      else if (word_hit(reg_addr_i, `LTA_IDX1_OFF))
        rdata_nxt = idx1_r;
      else
        rdata_nxt = 32'h0;  // Unmapped and entry words
    end
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r  <= lookup_table_access_pkg::ST_IDLE;
      op_r     <= lookup_table_access_pkg::OP_NOP;
      direct_r <= 1'b0;                                             // R7
      spare_r  <= 2'h0;
      launch_r <= 1'b0;
      ready_r  <= 1'b0;
      end_r    <= 1'b0;
      count_r  <= `LTA_CNT_RST;
      idx0_r   <= `LTA_IDX_RST;
      idx1_r   <= `LTA_IDX_RST;
      rdata_r  <= 32'h0;
      rsel_r   <= 1'b0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      direct_r <= direct_nxt;
      spare_r  <= spare_nxt;
      launch_r <= launch_nxt;
      ready_r  <= ready_nxt;
      end_r    <= end_nxt;
      count_r  <= count_nxt;
      idx0_r   <= idx0_nxt;
      idx1_r   <= idx1_nxt;
      rdata_r  <= rdata_nxt;
      rsel_r   <= rsel_nxt;
      rvalid_r <= reg_rd_i;
    end
  end

  // Entry bank hookup; table data loads on read and on each search hit
  assign eb.hw_load = (xfer_done && op_r == lookup_table_access_pkg::OP_READ)
                      || accept;                                    // R9 R3
  assign eb.hw_data = tbl_rdata_i;
  assign eb.sw_we   = reg_wr_i && entry_hit(reg_addr_i);            // R9
  assign eb.sw_idx  = reg_addr_i[3:2];
  assign eb.sw_data = reg_wdata_i;
  assign eb.rd_en   = reg_rd_i && entry_hit(reg_addr_i);
  assign eb.rd_idx  = reg_addr_i[3:2];

  // Register port outputs
  assign reg_rdata_o  = rsel_r ? eb.rd_data : rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // Engine request; key chosen by addressing mode
  assign tbl_req_o         = start_go;
  assign tbl_op_o          = op_r;
  assign tbl_direct_o      = direct_r;                              // R6 R7
  assign tbl_hash_fid_o    = direct_r ? 7'h0 : idx0_r[22:16];       // R10
  assign tbl_hash_mac_o    = direct_r ? 48'h0 : {idx0_r[15:0], idx1_r}; // R10
  assign tbl_direct_addr_o = direct_r ? idx1_r[11:0] : 12'h0;       // R11
  assign tbl_wdata_o       = eb.words;                              // R9
  assign tbl_entry_ack_o   = accept;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_launch;
    start_go;
  endsequence
  sequence s_finish;
    (state_r != lookup_table_access_pkg::ST_IDLE) && tbl_done_i;
  endsequence

  chk_launch_sets: assert property (s_launch // R2
    |=> launch_r && tbl_op_o == $past(reg_wdata_i[1:0]))
    else $error("launch flag or operation not taken");
  chk_finish_clears: assert property (s_finish // R2
    |=> !launch_r && state_r == lookup_table_access_pkg::ST_IDLE)
    else $error("launch flag not cleared at finish");
  chk_search_state: assert property (s_launch ##0 reg_wdata_i[1:0] == 2'h3 // R8
    |=> state_r == lookup_table_access_pkg::ST_SEARCH)
    else $error("search code did not start a search");
  chk_ready_set: assert property (accept |=> ready_r && !tbl_entry_ack_o) // R3
    else $error("ready flag not set on entry");
  chk_ready_clear: assert property (ready_r && entry4_rd && !accept |=> !ready_r) // R4
    else $error("ready flag not cleared by entry read");
  chk_either_end: assert property (srch_done // R5
    |=> ctrl_word[`LTA_CTRL_EITHER] && count_r == $past(tbl_count_i))
    else $error("combined bit or count wrong at search end");
  chk_count_hold: assert property (state_r == lookup_table_access_pkg::ST_IDLE // R1
    && !start_go |=> $stable(count_r))
    else $error("count changed outside search");
  chk_direct_key: assert property (tbl_direct_o // R6
    |-> tbl_direct_addr_o == idx1_r[11:0] && tbl_hash_mac_o == 48'h0)
    else $error("direct key wrong");
  chk_hash_key: assert property (!tbl_direct_o // R7
    |-> tbl_hash_mac_o == {idx0_r[15:0], idx1_r} && tbl_direct_addr_o == 12'h0)
    else $error("hashed key wrong");
  chk_mode_frozen: assert property (launch_r |=> $stable(op_r) && $stable(direct_r)) // R12
    else $error("mode bits changed while busy");

endmodule : lookup_table_access

// >>> core/lookup_table_access_consts.svh
`ifndef LOOKUP_TABLE_ACCESS_CONSTS_SVH
`define LOOKUP_TABLE_ACCESS_CONSTS_SVH

// Register byte addresses (each register is one aligned 32-bit word)
`define LTA_IDX0_OFF      16'h0410
`define LTA_IDX1_OFF      16'h0414
`define LTA_CTRL_OFF      16'h0418
`define LTA_ENTRY1_OFF    16'h0420
`define LTA_ENTRY4_OFF    16'h042c
// Highest byte of entry word 4; a read of its word clears the ready flag
`define LTA_ENTRY4_LAST   16'h042f

// Control register field positions
`define LTA_CTRL_LAUNCH   7
`define LTA_CTRL_READY    6
`define LTA_CTRL_EITHER   5
`define LTA_CTRL_DIRECT   2
`define LTA_CTRL_CNT_LSB  16
`define LTA_CTRL_CNT_MSB  29

// Writable mask of index register 0 (bit 31, group id, upper address)
`define LTA_IDX0_MASK     32'h807fffff

// Reset values
`define LTA_IDX_RST       32'h00000000
`define LTA_CNT_RST       14'h0000

`endif

// >>> core/lookup_table_access_pkg.sv
package lookup_table_access_pkg;

  // Operation field encoding
  typedef enum logic [1:0] {
    OP_NOP    = 2'h0,
    OP_WRITE  = 2'h1,
    OP_READ   = 2'h2,
    OP_SEARCH = 2'h3
  } op_t;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_XFER   = 3'h2,
    ST_SEARCH = 3'h4
  } state_t;

endpackage : lookup_table_access_pkg

// >>> core/entry_bank_if.sv
`timescale 1ns/1ps
// Link between the controller and the entry word bank
interface entry_bank_if;
  logic         sw_we;    // Software word write
  logic [1:0]   sw_idx;   // Word written by software
  logic [31:0]  sw_data;  // Software write data
  logic         hw_load;  // Load all four words from the table
  logic [127:0] hw_data;  // Table data, word 1 in the top bits
  logic         rd_en;    // Read request
  logic [1:0]   rd_idx;   // Word read
  logic [31:0]  rd_data;  // Registered read data
  logic [127:0] words;    // All four words, word 1 in the top bits

  modport bank (input sw_we, sw_idx, sw_data, hw_load, hw_data, rd_en, rd_idx,
                output rd_data, words);
  modport ctrl (output sw_we, sw_idx, sw_data, hw_load, hw_data, rd_en, rd_idx,
                input rd_data, words);
endinterface : entry_bank_if

// >>> core/entry_bank.sv
`timescale 1ns/1ps
module entry_bank
(
  // Clock and reset
  input  wire logic   clk_i,
  input  wire logic   sys_rst_i,
  // Controller side
  entry_bank_if.bank  eb
);

  logic [31:0] word_r   [4];  // Entry words
  logic [31:0] word_nxt [4];  // Next entry words
  logic [31:0] rd_r;          // Read data register
  logic [31:0] rd_nxt;        // Next read data

  // Per-word next value; table load beats software write
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_word
      always_comb
      begin
        word_nxt[g] = word_r[g];
        if (eb.hw_load)
          word_nxt[g] = eb.hw_data[127-32*g -: 32];
        else if (eb.sw_we && eb.sw_idx == 2'(g))
          word_nxt[g] = eb.sw_data;
      end
      assign eb.words[127-32*g -: 32] = word_r[g];
    end
  endgenerate

  // Read data selection
  always_comb
  begin
    rd_nxt = rd_r;
    if (eb.rd_en)
      rd_nxt = word_r[eb.rd_idx];
  end

  // Registers
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < 4; i++)
        word_r[i] <= 32'h0;
      rd_r <= 32'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        word_r[i] <= word_nxt[i];
      rd_r <= rd_nxt;
    end
  end

  assign eb.rd_data = rd_r;

  // Table results land in the entry words
  chk_load_lands: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
    eb.hw_load |=> eb.words == $past(eb.hw_data))
    else $error("entry words not loaded from table");

endmodule : entry_bank

// >>> bench/lookup_table_access_bench.sv
`timescale 1ns/1ps
`include "lookup_table_access_consts.svh"
module lookup_table_access_bench;
  // Clock, reset and register port
  logic         clk_i;
  logic         sys_rst_i;
  logic [15:0]  reg_addr_i;
  logic         reg_wr_i;
  logic         reg_rd_i;
  logic [31:0]  reg_wdata_i;
  logic [31:0]  reg_rdata_o;
  logic         reg_rvalid_o;
  // Engine request and answer
  logic         tbl_req_o;
  logic [1:0]   tbl_op_o;
  logic         tbl_direct_o;
  logic [6:0]   tbl_hash_fid_o;
  logic [47:0]  tbl_hash_mac_o;
  logic [11:0]  tbl_direct_addr_o;
  logic [127:0] tbl_wdata_o;
  logic         tbl_done_i;
  logic         tbl_entry_valid_i;
  logic [127:0] tbl_rdata_i;
  logic [13:0]  tbl_count_i;
  logic         tbl_entry_ack_o;
  // Bench state
  int           n_fail;
  int           compares;
  logic [31:0]  exp_q[$];
  logic         req_seen;
  logic [31:0]  idx0;
  logic [31:0]  idx1;
  logic [127:0] ent;
  logic [127:0] ent2;
  logic [13:0]  cnt;

  lookup_table_access dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .tbl_req_o(tbl_req_o),
    .tbl_op_o(tbl_op_o), .tbl_direct_o(tbl_direct_o), .tbl_hash_fid_o(tbl_hash_fid_o),
    .tbl_hash_mac_o(tbl_hash_mac_o), .tbl_direct_addr_o(tbl_direct_addr_o),
    .tbl_wdata_o(tbl_wdata_o), .tbl_done_i(tbl_done_i), .tbl_entry_valid_i(tbl_entry_valid_i),
    .tbl_rdata_i(tbl_rdata_i), .tbl_count_i(tbl_count_i), .tbl_entry_ack_o(tbl_entry_ack_o));

  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Compare one value, count it
  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Control register image
  function automatic logic [31:0] img(input logic [13:0] c, input logic l, input logic r,
                                      input logic e, input logic [1:0] s, input logic d,
                                      input logic [1:0] op);
    img = {2'h0, c, 8'h00, l, r, e, s, d, op};
  endfunction : img

  // One register write; notes the engine request of that cycle
  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    #1;
    req_seen = tbl_req_o;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : reg_write

  // One register read; expected data goes to the queue
  task automatic reg_read(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    exp_q.push_back(e);
    @(negedge clk_i);
    reg_rd_i = 1'b0;
  endtask : reg_read

  // One-cycle engine completion pulse
  task automatic engine_done(input logic [127:0] d, input logic [13:0] c);
    @(negedge clk_i);
    tbl_rdata_i = d;
    tbl_count_i = c;
    tbl_done_i  = 1'b1;
    @(negedge clk_i);
    tbl_done_i = 1'b0;
  endtask : engine_done

  // Bounded wait for the entry acknowledge
  task automatic wait_ack;
    int k;
    k = 0;
    #1;
    while (tbl_entry_ack_o !== 1'b1 && k < 10)
    begin
      @(negedge clk_i);
      #1;
      k++;
    end
    if (tbl_entry_ack_o !== 1'b1)
    begin
      check(tbl_entry_ack_o, 1'b1, "entry acknowledge timeout");
      finish_test();
    end
  endtask : wait_ack

  // Read data monitor, takes the oldest note
  initial
  begin
    forever
    begin
      @(negedge clk_i);
      if (reg_rvalid_o === 1'b1)
      begin
        if (exp_q.size() == 0)
          check(1'b1, 1'b0, "unexpected read data");
        else
          check(reg_rdata_o, exp_q.pop_front(), "read data");
      end
    end
  end

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk_i);
    check(1'b0, 1'b1, "run timeout");
    finish_test();
  end

  // Main sequence
  initial
  begin
    n_fail = 0;
    compares = 0;
    sys_rst_i = 1'b1;
    reg_addr_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 32'h00000000;
    tbl_done_i = 1'b0;
    tbl_entry_valid_i = 1'b0;
    tbl_rdata_i = 128'h0;
    tbl_count_i = 14'h0000;
    void'($urandom(96));
    repeat (6) @(negedge clk_i);
    sys_rst_i = 1'b0;
    // Reset values
    reg_read(`LTA_CTRL_OFF, 32'h00000000);
    reg_read(`LTA_IDX0_OFF, `LTA_IDX_RST);
    check(tbl_direct_o, 1'b0, "direct after reset");
    // Index registers and unmapped word readback
    idx0 = $urandom;
    idx1 = $urandom;
    reg_write(`LTA_IDX0_OFF, idx0);
    reg_write(`LTA_IDX1_OFF, idx1);
    reg_read(`LTA_IDX0_OFF, idx0 & `LTA_IDX0_MASK);
    reg_read(`LTA_IDX1_OFF, idx1);
    reg_read(16'h041c, 32'h00000000);
    // Start with no operation
    reg_write(`LTA_CTRL_OFF, 32'h00000080);
    check(req_seen, 1'b0, "request on nop");
    reg_read(`LTA_CTRL_OFF, 32'h00000000);
    // Fill entry words, then direct write
    ent = {$urandom, $urandom, $urandom, $urandom};
    for (int i = 0; i < 4; i++)
      reg_write(`LTA_ENTRY1_OFF + 16'(4 * i), ent[127 - 32 * i -: 32]);
    reg_write(`LTA_CTRL_OFF, 32'h00000085);
    check(req_seen, 1'b1, "write request");
    check(tbl_op_o, lookup_table_access_pkg::OP_WRITE, "write op");
    check(tbl_direct_o, 1'b1, "direct bit");
    check(tbl_direct_addr_o, idx1[11:0], "direct index");
    check({tbl_hash_fid_o, tbl_hash_mac_o}, 55'h0, "hash key in direct");
    check(tbl_wdata_o, ent, "write data");
    // Changes while busy are held off, spare bits still written
    reg_write(`LTA_CTRL_OFF, 32'h0000009a);
    check(req_seen, 1'b0, "request while busy");
    check({tbl_op_o, tbl_direct_o}, 3'h3, "fields while busy");
    reg_read(`LTA_CTRL_OFF, img(14'h0, 1'b1, 1'b0, 1'b0, 2'h3, 1'b1, 2'h1));
    engine_done(128'h0, 14'h0);
    reg_read(`LTA_CTRL_OFF, img(14'h0, 1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 2'h1));
    // Hashed read
    reg_write(`LTA_CTRL_OFF, 32'h00000082);
    check(req_seen, 1'b1, "read request");
    check(tbl_op_o, lookup_table_access_pkg::OP_READ, "read op");
    check(tbl_direct_o, 1'b0, "hashed mode");
    check(tbl_hash_fid_o, idx0[22:16], "group id key");
    check(tbl_hash_mac_o, {idx0[15:0], idx1}, "address key");
    check(tbl_direct_addr_o, 12'h000, "direct index in hashed");
    ent2 = {$urandom, $urandom, $urandom, $urandom};
    engine_done(ent2, 14'h0);
    reg_read(`LTA_CTRL_OFF, img(14'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 2'h2));
    for (int i = 0; i < 4; i++)
      reg_read(`LTA_ENTRY1_OFF + 16'(4 * i), ent2[127 - 32 * i -: 32]);
    // Search, two entries then end
    reg_write(`LTA_CTRL_OFF, 32'h00000083);
    check(req_seen, 1'b1, "search request");
    @(negedge clk_i);
    tbl_rdata_i = ent;
    tbl_entry_valid_i = 1'b1;
    wait_ack();
    @(negedge clk_i);
    tbl_rdata_i = ent2;
    #1;
    check(tbl_entry_ack_o, 1'b0, "ack while ready");
    reg_read(`LTA_CTRL_OFF, img(14'h0, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 2'h3));
    for (int i = 0; i < 4; i++)
      reg_read(`LTA_ENTRY1_OFF + 16'(4 * i), ent[127 - 32 * i -: 32]);
    wait_ack();
    @(negedge clk_i);
    tbl_entry_valid_i = 1'b0;
    reg_read(`LTA_ENTRY1_OFF, ent2[127:96]);
    reg_read(`LTA_CTRL_OFF, img(14'h0, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 2'h3));
    reg_read(`LTA_ENTRY4_OFF, ent2[31:0]);
    reg_read(`LTA_CTRL_OFF, img(14'h0, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0, 2'h3));
    cnt = 14'($urandom);
    engine_done(128'h0, cnt);
    reg_read(`LTA_CTRL_OFF, img(cnt, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 2'h3));
    // Drain outstanding reads
    for (int k = 0; k < 10 && exp_q.size() != 0; k++)
      @(negedge clk_i);
    check(exp_q.size(), 0, "reads left unanswered");
    finish_test();
  end
endmodule : lookup_table_access_bench
